// File: logic/lscr_frame_cap.sv
`timescale 1ns/1ps
`default_nettype none
// collects the 16 already-detected bits of one frame, msb first
module lscr_frame_cap
   import lscr_pkg::*;
#(
   parameter logic [7:0] DEV_ADDR = 8'h5A // arbitrary value
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic bit_valid,
   input wire logic bit_value,
   input wire logic frame_end,
   output var lscr_frame_t frame
);
   typedef struct packed {
      logic [15:0] shift;
      logic [4:0] count;
      lscr_frame_t frame;
   } lscr_cap_t;

   lscr_cap_t s_q;
   lscr_cap_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.frame.valid = 1'b0;
      if (bit_valid)
      begin
         s_d.shift = {s_q.shift[14:0], bit_value}; // see RL14
         if (s_q.count != 5'(LSCR_FRAME_BITS + 1))
         begin
            s_d.count = s_q.count + 5'h01;
         end
      end
      if (frame_end)
      begin
         // extra bits poison the frame; a short one never reaches 16
         if (s_q.count == 5'(LSCR_FRAME_BITS) && s_q.shift[15:8] == DEV_ADDR) // see RL15
         begin
            s_d.frame.valid = 1'b1;
            s_d.frame.ack_request = s_q.shift[LSCR_ACK_BIT]; // see RL13
            s_d.frame.reg_select = s_q.shift[LSCR_SEL_HI:LSCR_SEL_LO];
            s_d.frame.payload = s_q.shift[LSCR_PAY_HI:0];
         end
         s_d.count = 5'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign frame = s_q.frame;

   property p_short_rejected;
      @(posedge clk) disable iff (srst)
      (frame_end && s_q.count != 5'(LSCR_FRAME_BITS)) |=> !frame.valid;
   endproperty
   a_short_rejected: assert property (p_short_rejected) // see RL15
      else $error("frame with wrong bit count accepted");

   property p_addr_rejected;
      @(posedge clk) disable iff (srst)
      (frame_end && s_q.shift[15:8] != DEV_ADDR) |=> !frame.valid;
   endproperty
   a_addr_rejected: assert property (p_addr_rejected) // see RL15
      else $error("frame with foreign address accepted");
endmodule : lscr_frame_cap
`default_nettype wire

// File: logic/lscr_pkg.sv
// Summary of operation
// RL1 - select 00 loads group B level
// RL2 - select 01 loads group A level
// RL3 - codes 0-9: 0.1 mA steps
// RL4 - codes 10-31: 1.1 mA steps to 25.2
// RL5 - enable register bit 4 open-lamp detect
// RL6 - bits 3..0 enable B1, B2, A1-A3, A4
// RL7 - pump mode 00 automatic 1x/1.5x
// RL8 - pump mode 11 shutdown, sinks off
// RL9 - pump mode 10 forces 1x
// RL10 - pump mode 01 forces 1.5x
// RL11 - aux dim 20/40/70/100 percent steps
// RL12 - aux bit 0 enables aux sink
// RL13 - data byte: ack, select, payload
// RL14 - bytes arrive msb first
// RL15 - valid only with address match, 16 bits
// RL16 - update selected register at frame end
// RL17 - no read-back, only acknowledge returned
package lscr_pkg;
   // ------------------------------------------------------------
   // data byte layout
   // ------------------------------------------------------------
   localparam int LSCR_ACK_BIT = 7;
   localparam int LSCR_SEL_HI = 6;
   localparam int LSCR_SEL_LO = 5;
   localparam int LSCR_PAY_HI = 4;
   localparam int LSCR_BYTE_BITS = 8;
   localparam int LSCR_FRAME_BITS = 16;

   localparam logic [1:0] LSCR_SEL_GRP_B = 2'h0;
   localparam logic [1:0] LSCR_SEL_GRP_A = 2'h1;
   localparam logic [1:0] LSCR_SEL_ENABLE = 2'h2;
   localparam logic [1:0] LSCR_SEL_AUX = 2'h3;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int LSCR_OLD_BIT = 4;
   localparam int LSCR_B1_BIT = 3;
   localparam int LSCR_B2_BIT = 2;
   localparam int LSCR_A13_BIT = 1;
   localparam int LSCR_A4_BIT = 0;
   localparam int LSCR_MODE_HI = 4;
   localparam int LSCR_MODE_LO = 3;
   localparam int LSCR_DIM_A_BIT = 2;
   localparam int LSCR_DIM_B_BIT = 1;
   localparam int LSCR_AUXEN_BIT = 0;

   // ------------------------------------------------------------
   // reset values and current table
   // ------------------------------------------------------------
   localparam logic [4:0] LSCR_REG_RST = 5'h00;
   localparam logic [4:0] LSCR_LIN_LAST = 5'h09;
   // current in units of 0.1 mA
   localparam logic [7:0] LSCR_LIN_STEP = 8'h01;
   localparam logic [7:0] LSCR_HI_STEP = 8'h0B;
   localparam logic [7:0] LSCR_BASE = 8'h01;
   localparam logic [7:0] LSCR_AT_LIN_LAST = 8'h0A;
   // aux dimming in percent
   localparam logic [6:0] LSCR_DIM_20 = 7'h14;
   localparam logic [6:0] LSCR_DIM_40 = 7'h28;
   localparam logic [6:0] LSCR_DIM_70 = 7'h46;
   localparam logic [6:0] LSCR_DIM_100 = 7'h64;

   typedef enum logic [1:0] {LSCR_PUMP_AUTO, LSCR_PUMP_X15, LSCR_PUMP_X1, LSCR_PUMP_OFF}
      lscr_pump_t;

   typedef struct packed {
      logic valid;
      logic ack_request;
      logic [1:0] reg_select;
      logic [4:0] payload;
   } lscr_frame_t;

   typedef struct packed {
      logic [7:0] first_group_ma10;
      logic [7:0] second_group_ma10;
      logic sink_b1_en;
      logic sink_b2_en;
      logic sinks_a1_a3_en;
      logic fourth_a_sink_en;
      logic open_lamp_detect_en;
      lscr_pump_t pump_mode;
      logic [6:0] aux_dim_pct;
      logic aux_sink_en;
   } lscr_ctrl_t;
endpackage : lscr_pkg

// File: logic/lscr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lscr_regs
   import lscr_pkg::*;
#(
   parameter logic [7:0] DEV_ADDR = 8'h5A // arbitrary value
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic bit_valid,
   input wire logic bit_value,
   input wire logic frame_end,
   output var lscr_ctrl_t ctrl,
   output logic ack_strobe
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] level_to_ma10(input logic [4:0] code);
      logic [7:0] c;
      c = {3'h0, code};
      if (code <= LSCR_LIN_LAST)
         return LSCR_BASE + c * LSCR_LIN_STEP; // see RL3
      else
         return 8'(LSCR_AT_LIN_LAST + (c - {3'h0, LSCR_LIN_LAST}) * LSCR_HI_STEP); // see RL4
   endfunction : level_to_ma10

   function automatic logic [6:0] dim_pct(input logic a, input logic b);
      unique case ({a, b}) // see RL11
         2'b00: return LSCR_DIM_20;
         2'b10: return LSCR_DIM_40;
         2'b01: return LSCR_DIM_70;
         default: return LSCR_DIM_100;
      endcase
   endfunction : dim_pct

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [4:0] grp_b;
      logic [4:0] grp_a;
      logic [4:0] enable;
      logic [4:0] aux;
      lscr_ctrl_t ctrl;
      logic ack;
   } lscr_st_t;

   lscr_st_t s_q;
   lscr_st_t s_d;
   lscr_frame_t frame;

   lscr_frame_cap #(.DEV_ADDR(DEV_ADDR)) u_cap (
      .clk(clk),
      .srst(srst),
      .bit_valid(bit_valid),
      .bit_value(bit_value),
      .frame_end(frame_end),
      .frame(frame)
   );

   always_comb
   begin
      s_d = s_q;
      s_d.ack = 1'b0;
      if (frame.valid) // see RL16
      begin
         s_d.ack = frame.ack_request; // see RL17
         unique case (frame.reg_select)
            LSCR_SEL_GRP_B: s_d.grp_b = frame.payload; // see RL1
            LSCR_SEL_GRP_A: s_d.grp_a = frame.payload; // see RL2
            LSCR_SEL_ENABLE: s_d.enable = frame.payload;
            LSCR_SEL_AUX: s_d.aux = frame.payload;
         endcase
      end
      s_d.ctrl.first_group_ma10 = level_to_ma10(s_d.grp_a);
      s_d.ctrl.second_group_ma10 = level_to_ma10(s_d.grp_b);
      s_d.ctrl.open_lamp_detect_en = s_d.enable[LSCR_OLD_BIT]; // see RL5
      unique case (s_d.aux[LSCR_MODE_HI:LSCR_MODE_LO])
         2'b00: s_d.ctrl.pump_mode = LSCR_PUMP_AUTO; // see RL7
         2'b01: s_d.ctrl.pump_mode = LSCR_PUMP_X15; // see RL10
         2'b10: s_d.ctrl.pump_mode = LSCR_PUMP_X1; // see RL9
         2'b11: s_d.ctrl.pump_mode = LSCR_PUMP_OFF; // see RL8
      endcase
      // shutdown gates every sink, register contents survive it
      s_d.ctrl.sink_b1_en = s_d.enable[LSCR_B1_BIT] && s_d.ctrl.pump_mode != LSCR_PUMP_OFF; // see RL6
      s_d.ctrl.sink_b2_en = s_d.enable[LSCR_B2_BIT] && s_d.ctrl.pump_mode != LSCR_PUMP_OFF;
      s_d.ctrl.sinks_a1_a3_en = s_d.enable[LSCR_A13_BIT] && s_d.ctrl.pump_mode != LSCR_PUMP_OFF;
      s_d.ctrl.fourth_a_sink_en = s_d.enable[LSCR_A4_BIT] && s_d.ctrl.pump_mode != LSCR_PUMP_OFF;
      s_d.ctrl.aux_dim_pct = dim_pct(s_d.aux[LSCR_DIM_A_BIT], s_d.aux[LSCR_DIM_B_BIT]);
      s_d.ctrl.aux_sink_en = s_d.aux[LSCR_AUXEN_BIT] && s_d.ctrl.pump_mode != LSCR_PUMP_OFF; // see RL12
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_q <= '0;
         s_q.ctrl.first_group_ma10 <= LSCR_BASE;
         s_q.ctrl.second_group_ma10 <= LSCR_BASE;
         s_q.ctrl.aux_dim_pct <= LSCR_DIM_20;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign ctrl = s_q.ctrl;
   assign ack_strobe = s_q.ack;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_grp_b;
      @(posedge clk) disable iff (srst)
      (frame.valid && frame.reg_select == LSCR_SEL_GRP_B) |=> s_q.grp_b == $past(frame.payload);
   endproperty
   a_grp_b: assert property (p_grp_b) // see RL1
      else $error("group b level not loaded");

   property p_grp_a;
      @(posedge clk) disable iff (srst)
      (frame.valid && frame.reg_select == LSCR_SEL_GRP_A) |=> s_q.grp_a == $past(frame.payload)
         && $stable(s_q.grp_b);
   endproperty
   a_grp_a: assert property (p_grp_a) // see RL2
      else $error("group a level not loaded or b disturbed");

   property p_lin;
      @(posedge clk) disable iff (srst)
      (s_q.grp_a <= LSCR_LIN_LAST) |-> ctrl.first_group_ma10 == 8'(s_q.grp_a) + 8'h01;
   endproperty
   a_lin: assert property (p_lin) // see RL3
      else $error("low range current wrong");

   property p_top;
      @(posedge clk) disable iff (srst)
      (s_q.grp_b == 5'h1F) |-> ctrl.second_group_ma10 == 8'hFC;
   endproperty
   a_top: assert property (p_top) // see RL4
      else $error("top code not 25.2 mA");

   property p_old;
      @(posedge clk) disable iff (srst)
      ctrl.open_lamp_detect_en == s_q.enable[4];
   endproperty
   a_old: assert property (p_old) // see RL5
      else $error("open lamp detect mismatch");

   property p_off;
      @(posedge clk) disable iff (srst)
      (s_q.aux[4:3] == 2'b11) |-> !(ctrl.sink_b1_en || ctrl.sink_b2_en || ctrl.sinks_a1_a3_en
         || ctrl.fourth_a_sink_en || ctrl.aux_sink_en);
   endproperty
   a_off: assert property (p_off) // see RL8
      else $error("sink on in shutdown");

   property p_b1;
      @(posedge clk) disable iff (srst)
      (s_q.aux[4:3] != 2'b11) |-> ctrl.sink_b1_en == s_q.enable[3] && ctrl.fourth_a_sink_en == s_q.enable[0];
   endproperty
   a_b1: assert property (p_b1) // see RL6
      else $error("sink enable mismatch");

   property p_x1;
      @(posedge clk) disable iff (srst)
      (s_q.aux[4:3] == 2'b10) |-> ctrl.pump_mode == LSCR_PUMP_X1;
   endproperty
   a_x1: assert property (p_x1) // see RL9
      else $error("forced 1x not applied");

   property p_dim;
      @(posedge clk) disable iff (srst)
      (s_q.aux[2:1] == 2'b01) |-> ctrl.aux_dim_pct == 7'h46;
   endproperty
   a_dim: assert property (p_dim) // see RL11
      else $error("aux dim 70 percent wrong");

   property p_ack;
      @(posedge clk) disable iff (srst)
      ack_strobe |-> $past(frame.valid) && $past(frame.ack_request);
   endproperty
   a_ack: assert property (p_ack) // see RL17
      else $error("ack without valid request");
endmodule : lscr_regs
`default_nettype wire

// File: sim/lscr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host side: hands over detected line bits of one frame
// ------------------------------------------------------------
module lscr_host (
   input wire logic clk,
   output logic bit_valid,
   output logic bit_value,
   output logic frame_end
);
   initial
   begin
      bit_valid = 1'b0;
      bit_value = 1'b0;
      frame_end = 1'b0;
   end

   // address byte then data byte, msb first; gap stalls between bits
   task automatic send(input logic [7:0] addr, input logic [7:0] data, input int nbits,
                       input int gap);
      logic [16:0] word;
      word = {addr, data, 1'b1};
      for (int i = 0; i < nbits; i++)
      begin
         @(posedge clk);
         bit_valid <= 1'b1;
         bit_value <= word[16 - i];
         @(posedge clk);
         bit_valid <= 1'b0;
         // no stale bit between pulses: show the inverse
         bit_value <= ~word[16 - i];
         repeat (gap) @(posedge clk);
      end
      @(posedge clk);
      frame_end <= 1'b1;
      @(posedge clk);
      frame_end <= 1'b0;
   endtask : send
endmodule : lscr_host
`default_nettype wire

// File: sim/test_led_sink_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_led_sink_control_regs;
   import lscr_pkg::*;
   // ------------------------------------------------------------
   // bench signals and model state
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR = 8'h3C; // arbitrary value
   logic clk;
   logic srst;
   logic bit_valid;
   logic bit_value;
   logic frame_end;
   logic ack_strobe;
   lscr_ctrl_t ctrl;
   int err_total;
   int tests_run;
   int seed;
   int regs [4];

   lscr_host host (.clk(clk), .bit_valid(bit_valid), .bit_value(bit_value),
                   .frame_end(frame_end));
   lscr_regs #(.DEV_ADDR(ADDR)) uut (.clk(clk), .srst(srst), .bit_valid(bit_valid),
      .bit_value(bit_value), .frame_end(frame_end), .ctrl(ctrl), .ack_strobe(ack_strobe));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic logic [7:0] cur(input int code);
      return (code <= 9) ? 8'(code + 1) : 8'(10 + (code - 9) * 11);
   endfunction : cur

   function automatic lscr_ctrl_t model();
      lscr_ctrl_t e;
      logic on;
      // shutdown gates the sinks but keeps what was written
      on = regs[3][4:3] != 2'h3;
      e.first_group_ma10 = cur(regs[1]);
      e.second_group_ma10 = cur(regs[0]);
      e.open_lamp_detect_en = regs[2][4];
      e.sink_b1_en = regs[2][3] & on;
      e.sink_b2_en = regs[2][2] & on;
      e.sinks_a1_a3_en = regs[2][1] & on;
      e.fourth_a_sink_en = regs[2][0] & on;
      e.pump_mode = lscr_pump_t'(regs[3][4:3]);
      case (regs[3][2:1])
         0: e.aux_dim_pct = 7'h14;
         2: e.aux_dim_pct = 7'h28;
         1: e.aux_dim_pct = 7'h46;
         default: e.aux_dim_pct = 7'h64;
      endcase
      e.aux_sink_en = regs[3][0] & on;
      return e;
   endfunction : model

   // ------------------------------------------------------------
   // compares, frames, closing
   // ------------------------------------------------------------
   task automatic cmp_ctrl(input lscr_ctrl_t exp);
      tests_run++;
      if (ctrl !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: ctrl %h expected %h", $time, ctrl, exp);
      end
   endtask : cmp_ctrl

   task automatic cmp_ack(input logic exp);
      tests_run++;
      if (ack_strobe !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: ack %h expected %h", $time, ack_strobe, exp);
      end
   endtask : cmp_ack

   task automatic frame(input logic [7:0] addr, input logic [7:0] data, input int nbits);
      logic good;
      int gap;
      good = (addr == ADDR) && (nbits == 16);
      gap = ($random(seed) & 1) ? 0 : ($random(seed) & 3);
      host.send(addr, data, nbits, gap);
      if (good)
         regs[data[6:5]] = data[4:0];
      // ack stands for one cycle only, right after the edge that follows frame end
      @(posedge clk);
      #1;
      cmp_ack(good & data[7]);
      cmp_ctrl(model());
      @(posedge clk);
      #1;
      cmp_ack(1'b0);
   endtask : frame

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   initial
   begin
      for (int i = 0; i < 100000; i++)
         @(posedge clk);
      err_total++;
      finish_test();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      seed = 32'h3B91193C;
      err_total = 0;
      tests_run = 0;
      regs = '{default: 0};
      srst = 1'b1;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      cmp_ctrl(model());
      // every code of every register, ack asked at random
      for (int s = 0; s < 4; s++)
         for (int p = 0; p < 32; p++)
            frame(ADDR, {1'($random(seed)), 2'(s), 5'(p)}, 16);
      frame(ADDR, 8'hCF, 16);
      frame(ADDR ^ 8'h01, 8'hC0, 16);
      frame(ADDR ^ 8'h80, 8'hA0, 16);
      frame(ADDR, 8'hE5, 15);
      frame(ADDR, 8'hE5, 17);
      repeat (40) frame(ADDR, 8'($random(seed)), 16);
      @(posedge clk);
      srst <= 1'b1;
      regs = '{default: 0};
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      cmp_ctrl(model());
      // switch the B1, B2, A1-A3 and A4 sinks on first, so that shutdown has something to gate
      frame(ADDR, 8'h5F, 16);
      frame(ADDR, 8'hF9, 16);
      frame(ADDR, 8'h60, 16);
      finish_test();
   end
endmodule : test_led_sink_control_regs
`default_nettype wire
